// File: common/gpc_pkg.sv
// Shared constants and carrier types for the pin control block
package gpc_pkg;

  localparam int CLK_MHZ              = 32'h0000000a;
  localparam int DEBOUNCE_TIME_US     = 32'h000003e8;
  localparam int DEBOUNCE_CYCLES_DFLT = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int DEB_CNT_W            = 32'h00000014;

  localparam int SYNC_W     = 32'h00000003;
  localparam int SYNC_PIN   = 32'h00000000;
  localparam int SYNC_OSC   = 32'h00000001;
  localparam int SYNC_CLK2M = 32'h00000002;

  localparam logic [15:0] ADR_CFG    = 16'h403c;
  localparam logic [15:0] ADR_STATUS = 16'h4040;
  localparam logic [15:0] ADR_OUTLVL = 16'h4044;
  localparam logic [15:0] CFG_RESET  = 16'ha400;
  localparam logic [15:0] CFG_WMASK  = 16'hfe8f;
  localparam logic [15:0] OUTLVL_WMASK = 16'h0001;

  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_RSV  = 2'h3;

  localparam logic [3:0] IN_GP_LONG    = 4'h0;
  localparam logic [3:0] IN_GP         = 4'h1;
  localparam logic [3:0] IN_PWR_ONOFF  = 4'h2;
  localparam logic [3:0] IN_SLP_WAKE   = 4'h3;
  localparam logic [3:0] IN_SLP_WAKE_L = 4'h4;
  localparam logic [3:0] IN_SLP        = 4'h5;
  localparam logic [3:0] IN_PWR_ON     = 4'h6;
  localparam logic [3:0] IN_WDOG       = 4'h7;
  localparam logic [3:0] IN_VS_ONE     = 4'h8;
  localparam logic [3:0] IN_VS_TWO     = 4'h9;
  localparam logic [3:0] IN_HWEN_ONE   = 4'ha;
  localparam logic [3:0] IN_HWEN_TWO   = 4'hb;
  localparam logic [3:0] IN_HWCT_ONE   = 4'hc;
  localparam logic [3:0] IN_HWCT_TWO   = 4'hd;
  localparam logic [3:0] IN_HWCT_ONE_L = 4'he;
  localparam logic [3:0] IN_HWCT_TWO_L = 4'hf;

  localparam logic [3:0] OUT_GP       = 4'h0;
  localparam logic [3:0] OUT_OSC      = 4'h1;
  localparam logic [3:0] OUT_ON       = 4'h2;
  localparam logic [3:0] OUT_SLEEP    = 4'h3;
  localparam logic [3:0] OUT_CHANGE   = 4'h4;
  localparam logic [3:0] OUT_VSD_ONE  = 4'h8;
  localparam logic [3:0] OUT_VSD_TWO  = 4'h9;
  localparam logic [3:0] OUT_EXT_ONE  = 4'ha;
  localparam logic [3:0] OUT_EXT_TWO  = 4'hb;
  localparam logic [3:0] OUT_SYS_GOOD = 4'hc;
  localparam logic [3:0] OUT_CNV_GOOD = 4'hd;
  localparam logic [3:0] OUT_CLK2M    = 4'he;
  localparam logic [3:0] OUT_AUX_RST  = 4'hf;

  typedef struct packed {
    logic       pin_direction;
    logic [1:0] pull_resistor_select;
    logic       edge_mode_select;
    logic       supply_domain_select;
    logic       pin_polarity;
    logic       drive_type_select;
    logic       rsv8;
    logic       pin_active;
    logic [2:0] rsv6_4;
    logic [3:0] pin_function_code;
  } gpc_cfg_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } gpc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } gpc_wb_rsp_t;

  typedef struct packed {
    logic gp_level;
    logic power_onoff_req;
    logic sleep_wake_req;
    logic sleep_req;
    logic power_on_req;
    logic watchdog_rst;
    logic voltage_scale_select_one;
    logic voltage_scale_select_two;
    logic hw_enable_one;
    logic hw_enable_two;
    logic hw_control_one;
    logic hw_control_two;
  } gpc_func_req_t;

  typedef struct packed {
    logic on_state;
    logic sleep_state;
    logic state_change;
    logic vscale_done_one;
    logic vscale_done_two;
    logic ext_power_en_one;
    logic ext_power_en_two;
    logic system_supply_good;
    logic converter_supply_good;
    logic aux_reset;
  } gpc_func_src_t;

endpackage

// File: src/gpc_sync.sv
// Two-stage synchroniser for pin and foreign clock inputs
`timescale 1ns/1ps
`default_nettype none
module gpc_sync
  import gpc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic [SYNC_W-1:0] d,
  output logic      [SYNC_W-1:0] q
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } gpc_sync_st_t;

  gpc_sync_st_t st;
  gpc_sync_st_t next_st;

  always_comb
  begin
    next_st.meta   = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign q = st.stable;

endmodule
`default_nettype wire

// File: src/gpc_debounce.sv
// Stable-level filter used for the long debounce input functions
`timescale 1ns/1ps
`default_nettype none
module gpc_debounce
  import gpc_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = DEBOUNCE_CYCLES_DFLT
)
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic level_in,
  output logic      level_out
);

  typedef struct packed {
    logic                 level;
    logic [DEB_CNT_W-1:0] cnt;
  } gpc_deb_st_t;

  gpc_deb_st_t st;
  gpc_deb_st_t next_st;

  // A level that differs must hold for the full period before it is taken
  always_comb
  begin
    next_st = st;
    if (level_in == st.level)
      next_st.cnt = '0;
    else if (st.cnt == DEB_CNT_W'(STABLE_CYCLES - 1))
    begin
      next_st.level = level_in;
      next_st.cnt   = '0;
    end
    else
      next_st.cnt = st.cnt + DEB_CNT_W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign level_out = st.level;

endmodule
`default_nettype wire

// File: src/gpc_pin_control.sv
// Pin five control: config register, function select, pad drive, events
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_control
#(
  parameter int unsigned DEBOUNCE_CYCLES = gpc_pkg::DEBOUNCE_CYCLES_DFLT
)
(
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  ce,
  input  wire gpc_pkg::gpc_wb_req_t  wb_req,
  output gpc_pkg::gpc_wb_rsp_t       wb_rsp,
  input  wire logic                  pin_in,
  output logic                       pin_out,
  output logic                       pin_oe,
  output logic                       pull_up_en,
  output logic                       pull_down_en,
  output logic                       supply_domain_select,
  output logic                       pin_event,
  output gpc_pkg::gpc_func_req_t     func_req,
  input  wire gpc_pkg::gpc_func_src_t func_src,
  input  wire logic                  osc_clk_32k,
  input  wire logic                  power_clk_2m
);
  import gpc_pkg::*;

  typedef struct packed {
    gpc_cfg_t      cfg;
    logic          out_level;
    logic          prev_lvl;
    logic          ack;
    logic [31:0]   rdat;
    logic          pin_out;
    logic          pin_oe;
    logic          pull_up;
    logic          pull_down;
    logic          supply;
    logic          event_p;
    gpc_func_req_t req;
  } gpc_st_t;

  gpc_st_t           st;
  gpc_st_t           next_st;
  logic [SYNC_W-1:0] sync_q;
  logic              deb_lvl;
  logic              long_sel;
  logic              cur_lvl;
  logic              in_mode;
  logic              out_src;
  logic              out_valid;
  logic              drv_lvl;
  logic              bus_req;
  logic [15:0]       wr_cfg;
  logic [15:0]       wr_out;

  // Polarity: 0 means active low, so the level is inverted
  function automatic logic apply_pol(input logic lvl, input logic pol);
    apply_pol = pol ? lvl : ~lvl;
  endfunction

  // Byte-lane merge of a 16-bit register with write mask
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel,
                                             input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0])
      v[7:0] = wdat[7:0];
    if (sel[1])
      v[15:8] = wdat[15:8];
    lane_merge = v & mask;
  endfunction

  // Codes whose input path goes through the long filter
  function automatic logic is_long(input logic [3:0] code);
    is_long = (code == IN_GP_LONG) || (code == IN_SLP_WAKE_L) ||
              (code == IN_HWCT_ONE_L) || (code == IN_HWCT_TWO_L);
  endfunction

  gpc_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .d        ({power_clk_2m, osc_clk_32k, pin_in}),
    .q        (sync_q)
  );

  gpc_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .core_clk  (core_clk),
    .srst      (srst),
    .ce        (ce),
    .level_in  (apply_pol(sync_q[SYNC_PIN], st.cfg.pin_polarity)),
    .level_out (deb_lvl)
  );

  always_comb
  begin
    long_sel = is_long(st.cfg.pin_function_code);
    cur_lvl  = long_sel ? deb_lvl
             : apply_pol(sync_q[SYNC_PIN], st.cfg.pin_polarity);
    in_mode  = st.cfg.pin_active && st.cfg.pin_direction;
    bus_req  = wb_req.cyc && wb_req.stb && !st.ack;
    wr_cfg   = lane_merge(st.cfg, wb_req.dat, wb_req.sel, CFG_WMASK);
    wr_out   = lane_merge({15'h0000, st.out_level}, wb_req.dat,
                          wb_req.sel, OUTLVL_WMASK);
  end

  // Output source mux; reserved codes give no drive
  always_comb
  begin
    out_valid = 1'b1;
    out_src   = 1'b0;
    unique case (st.cfg.pin_function_code)
      OUT_GP:       out_src = st.out_level;
      OUT_OSC:      out_src = sync_q[SYNC_OSC];
      OUT_ON:       out_src = func_src.on_state;
      OUT_SLEEP:    out_src = func_src.sleep_state;
      OUT_CHANGE:   out_src = func_src.state_change;
      OUT_VSD_ONE:  out_src = func_src.vscale_done_one;
      OUT_VSD_TWO:  out_src = func_src.vscale_done_two;
      OUT_EXT_ONE:  out_src = func_src.ext_power_en_one;
      OUT_EXT_TWO:  out_src = func_src.ext_power_en_two;
      OUT_SYS_GOOD: out_src = func_src.system_supply_good;
      OUT_CNV_GOOD: out_src = func_src.converter_supply_good;
      OUT_CLK2M:    out_src = sync_q[SYNC_CLK2M];
      OUT_AUX_RST:  out_src = func_src.aux_reset;
      default:      out_valid = 1'b0;
    endcase
    drv_lvl = apply_pol(out_src, st.cfg.pin_polarity);
  end

  always_comb
  begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.rdat  = 32'h00000000;
    // Single-cycle answer; unmapped reads return zero, writes are dropped
    if (bus_req)
    begin
      next_st.ack = 1'b1;
      unique case (wb_req.adr)
        ADR_CFG:
        begin
          next_st.rdat = {16'h0000, st.cfg};
          if (wb_req.we)
            next_st.cfg = gpc_cfg_t'(wr_cfg);
        end
        ADR_STATUS:
          next_st.rdat = {30'h00000000, st.prev_lvl, sync_q[SYNC_PIN]};
        ADR_OUTLVL:
        begin
          next_st.rdat = {31'h00000000, st.out_level};
          if (wb_req.we)
            next_st.out_level = wr_out[0];
        end
        default:
          next_st.rdat = 32'h00000000;
      endcase
    end

    next_st.supply    = st.cfg.supply_domain_select;
    next_st.pull_up   = (st.cfg.pull_resistor_select == PULL_UP);
    next_st.pull_down = (st.cfg.pull_resistor_select == PULL_DOWN);

    // Open drain only ever sinks, so the driven value stays low
    if (!st.cfg.pin_active || st.cfg.pin_direction || !out_valid)
    begin
      next_st.pin_oe  = 1'b0;
      next_st.pin_out = 1'b0;
    end
    else if (st.cfg.drive_type_select)
    begin
      next_st.pin_oe  = ~drv_lvl;
      next_st.pin_out = 1'b0;
    end
    else
    begin
      next_st.pin_oe  = 1'b1;
      next_st.pin_out = drv_lvl;
    end

    // Edge seen on the polarity-corrected level covers both polarities
    next_st.prev_lvl = cur_lvl;
    if (!in_mode)
      next_st.event_p = 1'b0;
    else if (st.cfg.edge_mode_select)
      next_st.event_p = cur_lvl ^ st.prev_lvl;
    else
      next_st.event_p = cur_lvl && !st.prev_lvl;

    next_st.req = '0;
    if (in_mode)
    begin
      unique case (st.cfg.pin_function_code)
        IN_GP_LONG, IN_GP:
          next_st.req.gp_level = cur_lvl;
        IN_PWR_ONOFF:
          next_st.req.power_onoff_req = cur_lvl;
        IN_SLP_WAKE, IN_SLP_WAKE_L:
          next_st.req.sleep_wake_req = cur_lvl;
        IN_SLP:
          next_st.req.sleep_req = cur_lvl;
        IN_PWR_ON:
          next_st.req.power_on_req = cur_lvl;
        IN_WDOG:
          next_st.req.watchdog_rst = cur_lvl;
        IN_VS_ONE:
          next_st.req.voltage_scale_select_one = cur_lvl;
        IN_VS_TWO:
          next_st.req.voltage_scale_select_two = cur_lvl;
        IN_HWEN_ONE:
          next_st.req.hw_enable_one = cur_lvl;
        IN_HWEN_TWO:
          next_st.req.hw_enable_two = cur_lvl;
        IN_HWCT_ONE, IN_HWCT_ONE_L:
          next_st.req.hw_control_one = cur_lvl;
        IN_HWCT_TWO, IN_HWCT_TWO_L:
          next_st.req.hw_control_two = cur_lvl;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st     <= '0;
      st.cfg <= gpc_cfg_t'(CFG_RESET);
    end
    else if (ce)
      st <= next_st;
  end

  assign wb_rsp.ack           = st.ack;
  assign wb_rsp.dat           = st.rdat;
  assign pin_out              = st.pin_out;
  assign pin_oe               = st.pin_oe;
  assign pull_up_en           = st.pull_up;
  assign pull_down_en         = st.pull_down;
  assign supply_domain_select = st.supply;
  assign pin_event            = st.event_p;
  assign func_req             = st.req;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_reset_cfg;
    $fell(srst) |-> st.cfg == gpc_cfg_t'(CFG_RESET);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("config not at reset value after reset");

  property p_pull_down;
    ce && st.cfg.pull_resistor_select == PULL_DOWN
      |=> pull_down_en && !pull_up_en;
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down select not applied");

  property p_pull_rsv;
    ce && st.cfg.pull_resistor_select == PULL_RSV
      |=> !pull_down_en && !pull_up_en;
  endproperty
  a_pull_rsv: assert property (p_pull_rsv)
    else $error("reserved pull setting enabled a resistor");

  property p_single_edge;
    ce && in_mode && !st.cfg.edge_mode_select
      |=> pin_event == ($past(cur_lvl) && !$past(st.prev_lvl));
  endproperty
  a_single_edge: assert property (p_single_edge)
    else $error("single-edge event mismatch");

  property p_both_edges;
    ce && in_mode && st.cfg.edge_mode_select && (cur_lvl != st.prev_lvl)
      |=> pin_event;
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("edge missed in both-edge mode");

  property p_supply;
    ce |=> supply_domain_select == $past(st.cfg.supply_domain_select);
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply select not following config");

  property p_open_drain;
    ce && st.cfg.drive_type_select |=> !pin_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drove high");

  property p_tristate;
    ce && !st.cfg.pin_active |=> !pin_oe ##1 (!pin_oe || st.cfg.pin_active
      || !ce);
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("disabled pin was driven");

  property p_gp_out;
    ce && st.cfg.pin_active && !st.cfg.pin_direction &&
      !st.cfg.drive_type_select && st.cfg.pin_function_code == OUT_GP
      |=> pin_oe && pin_out == apply_pol($past(st.out_level),
                                         $past(st.cfg.pin_polarity));
  endproperty
  a_gp_out: assert property (p_gp_out)
    else $error("general output level wrong");

  property p_wdog_in;
    ce && in_mode && st.cfg.pin_function_code == IN_WDOG
      |=> func_req.watchdog_rst == $past(cur_lvl) && !func_req.gp_level;
  endproperty
  a_wdog_in: assert property (p_wdog_in)
    else $error("watchdog input not routed");

  c_cfg_write: cover property (ce && bus_req && wb_req.we &&
                               wb_req.adr == ADR_CFG);
  c_both_edge: cover property (pin_event && st.cfg.edge_mode_select);
  c_od_low:    cover property (pin_oe && st.cfg.drive_type_select);

endmodule
`default_nettype wire

// File: testbench/gpc_pin_partner.sv
// Far-side model: external logic that drives or releases pin five
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_partner
(
  input  wire logic core_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  input  wire logic ext_en,
  input  wire logic ext_level,
  output logic      pin_level
);
  logic float_pat = 1'b0;

  // A released pad with no pull must not read as a steady level
  always @(posedge core_clk)
    float_pat <= ~float_pat;

  always_comb
  begin
    if (pin_oe === 1'b1)
      pin_level = pin_out;
    else if (ext_en === 1'b1)
      pin_level = ext_level;
    else if (pull_up_en === 1'b1)
      pin_level = 1'b1;
    else if (pull_down_en === 1'b1)
      pin_level = 1'b0;
    else
      pin_level = float_pat;
  end
endmodule
`default_nettype wire

// File: testbench/test_gpc_pin_control.sv
// Self-checking bench for the pin five control block
`timescale 1ns/1ps
`default_nettype none
module test_gpc_pin_control;
  import gpc_pkg::*;

  localparam int unsigned DEB = 4;
  localparam int REQ_BIT [16] = '{11,11,10,9,9,8,7,6,5,4,3,2,1,0,1,0};
  localparam int SRC_BIT [16] = '{-1,-1,9,8,7,-1,-1,-1,6,5,4,3,2,1,-1,0};
  localparam logic [15:0] EV_CFG [5] =
    '{16'h8481, 16'h8081, 16'h9481, 16'h9081, 16'h8401};
  localparam logic [11:0] EV_RISE [5] = '{1, 0, 1, 1, 0};
  localparam logic [11:0] EV_FALL [5] = '{0, 1, 1, 1, 0};
  localparam logic [11:0] EV_REQ [5] = '{12'h800, 0, 12'h800, 0, 0};
  localparam logic [15:0] OC_CFG [3] = '{16'h0080, 16'h0680, 16'h0400};
  localparam logic [11:0] OC_EXP [6] = '{3, 2, 2, 0, 0, 0};

  logic          core_clk;
  logic          srst;
  logic          ce;
  gpc_wb_req_t   wb_req;
  gpc_wb_rsp_t   wb_rsp;
  logic          pin_in;
  logic          pin_out;
  logic          pin_oe;
  logic          pull_up_en;
  logic          pull_down_en;
  logic          supply_domain_select;
  logic          pin_event;
  gpc_func_req_t func_req;
  gpc_func_src_t func_src;
  logic          osc_clk_32k;
  logic          power_clk_2m;
  logic          ext_en;
  logic          ext_level;
  logic [31:0]   rd;
  logic [11:0]   exp_req;
  logic [9:0]    src_v;
  int            errors;
  int            n_compared;
  int            n_ev = 0;
  int            ev_base;
  int            idx;

  gpc_pin_control #(.DEBOUNCE_CYCLES(DEB)) i_gpc_pin_control (
    .core_clk(core_clk), .srst(srst), .ce(ce), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .supply_domain_select(supply_domain_select), .pin_event(pin_event),
    .func_req(func_req), .func_src(func_src), .osc_clk_32k(osc_clk_32k),
    .power_clk_2m(power_clk_2m));

  gpc_pin_partner i_gpc_pin_partner (
    .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .ext_en(ext_en), .ext_level(ext_level), .pin_level(pin_in));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (pin_event === 1'b1)
      n_ev <= n_ev + 1;

  task automatic conclude();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Classic cycle; the master never assumes the slave's latency
  task automatic wb_cycle(input logic we, input logic [15:0] adr,
                          input logic [3:0] sel, input logic [31:0] wdat,
                          output logic [31:0] rdat);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
                dat: wdat};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && n < 50);
    chk_word({31'h0, wb_rsp.ack}, 32'h1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [15:0] adr, input logic [15:0] d);
    wb_cycle(1'b1, adr, 4'h3, {16'h0, d}, rd);
  endtask

  task automatic rdc(input logic [15:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 4'h3, 32'h0, rd);
    chk_word(rd, exp);
  endtask

  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    wb_req = '0;
    func_src = '0;
    osc_clk_32k = 1'b0;
    power_clk_2m = 1'b0;
    ext_en = 1'b0;
    ext_level = 1'b0;
    errors = 0;
    n_compared = 0;
    wait_n(16);
    srst <= 1'b0;
    wait_n(2);
    rdc(ADR_CFG, 32'h0000a400);
    chk_pins({8'h0, pull_up_en, pull_down_en, pin_oe,
              supply_domain_select}, 12'h004);
    wr(ADR_CFG, 16'hffff);
    rdc(ADR_CFG, 32'h0000fe8f);
    wait_n(2);
    chk_pins({9'h0, supply_domain_select, pull_up_en,
              pull_down_en}, 12'h004);
    wb_cycle(1'b1, ADR_CFG, 4'h1, 32'h0, rd);
    rdc(ADR_CFG, 32'h0000fe00);
    for (int p = 0; p < 3; p++)
    begin
      wr(ADR_CFG, {1'b1, p[1:0], 13'h0});
      wait_n(2);
      chk_pins({10'h0, pull_up_en, pull_down_en},
               {10'h0, p == 2, p == 1});
    end
    wr(16'h4050, 16'hffff);
    rdc(16'h4050, 32'h0);
    // Input functions, short and long paths
    ext_en <= 1'b1;
    for (int c = 0; c < 16; c++)
    begin
      ext_level <= 1'b0;
      wr(ADR_CFG, 16'h8480 | c[15:0]);
      wait_n(2 * DEB + 8);
      exp_req = 12'h1 << REQ_BIT[c];
      ext_level <= 1'b1;
      wait_n(5);
      chk_pins(func_req, (c == 0 || c == 4 || c >= 14) ? 12'h0
                                                       : exp_req);
      wait_n(DEB + 4);
      chk_pins(func_req, exp_req);
      ext_level <= 1'b0;
      wait_n(DEB + 8);
      chk_pins(func_req, 12'h0);
    end
    // Events per edge mode, polarity and tri-state
    for (int k = 0; k < 5; k++)
    begin
      ext_level <= 1'b0;
      wr(ADR_CFG, EV_CFG[k]);
      wait_n(8);
      // Counter has one driver; the scenario looks at the growth only
      ev_base = n_ev;
      ext_level <= 1'b1;
      wait_n(8);
      chk_pins(12'(n_ev - ev_base), EV_RISE[k]);
      chk_pins(func_req, EV_REQ[k]);
      rdc(ADR_STATUS, {30'h0, EV_CFG[k][10], 1'b1});
      ext_level <= 1'b0;
      wait_n(8);
      chk_pins(12'(n_ev - ev_base), EV_RISE[k] + EV_FALL[k]);
    end
    // Output functions: only the selected source reaches the pad
    ext_en <= 1'b0;
    for (int c = 0; c < 16; c++)
      for (int lv = 0; lv < 2; lv++)
      begin
        idx = SRC_BIT[c];
        src_v = (idx < 0) ? 10'h0 : (10'h1 << idx);
        func_src <= (lv == 1) ? src_v : ~src_v;
        osc_clk_32k <= (c == 1) ? lv[0] : ~lv[0];
        power_clk_2m <= (c == 14) ? lv[0] : ~lv[0];
        wr(ADR_CFG, 16'h0480 | c[15:0]);
        wr(ADR_OUTLVL, (c == 0) ? {15'h0, lv[0]} : {15'h0, ~lv[0]});
        wait_n(6);
        chk_pins({10'h0, pin_oe, pin_oe & pin_out},
                 (c >= 5 && c <= 7) ? 12'h0
                                    : {10'h0, 1'b1, lv[0]});
      end
    // Output polarity, open drain and tri-state on the general output
    for (int k = 0; k < 3; k++)
      for (int lv = 0; lv < 2; lv++)
      begin
        wr(ADR_CFG, OC_CFG[k]);
        wr(ADR_OUTLVL, {15'h0, lv[0]});
        wait_n(3);
        chk_pins({10'h0, pin_oe, pin_oe & pin_out},
                 OC_EXP[k * 2 + lv]);
      end
    // Clock enable low freezes the pad drive
    wr(ADR_CFG, 16'h0482);
    func_src <= 10'h200;
    wait_n(3);
    ce <= 1'b0;
    func_src <= 10'h000;
    wait_n(4);
    chk_pins({10'h0, pin_oe, pin_out}, 12'h003);
    ce <= 1'b1;
    wait_n(3);
    chk_pins({10'h0, pin_oe, pin_out}, 12'h002);
    // Reset in mid-run restores the defaults
    srst <= 1'b1;
    wait_n(2);
    srst <= 1'b0;
    wait_n(2);
    rdc(ADR_CFG, 32'h0000a400);
    conclude();
  end

  // Whole run is about 1400 cycles; this bound only cuts a hang
  initial
  begin
    wait_n(30000);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
